// File: hdl/pcs_core.v
// Purpose: Program counter, 16-level return stack and indirect pointers.
// Assumes: Avalon-MM slave, one clock, synchronous active-low reset.
// Notes:   Commands from the decoder arrive as register writes.
// Operation
// - PC is 15 bits; low byte readable, upper seven taken from latch.
// - Every reset clears the whole program counter.
// - Writing the PC low byte loads upper bits from latch together.
// - Call loads bits 10..0 from operand, 14..11 from latch 6..3.
// - Computed call loads low byte from W, upper from latch.
// - Branch by W loads PC+1+W, W unsigned.
// - Relative branch loads PC+1+signed operand, crossing pages.
// - Sixteen 15-bit stack entries kept apart from other memory.
// - Calls and interrupts push, returns pop; latch never touched.
// - With fault reset off, stack wraps circularly.
// - Overflow and underflow flags set regardless of fault reset.
// - Five-bit pointer selects entry seen through top-of-stack pair.
// - Push increments then stores; pop restores then decrements.
// - Pointer 0x1F means empty; first push gives 0x00.
// - With fault reset on, overflow or underflow resets the PC and stack pointer.
// - Indirect port pointing at a port reads zero, write dropped.
// - Each indirect pointer is 16 bits from high and low bytes.
// - Pointer 0x000..0xFFF reaches the same absolute data address.
// - Pointer 0x2000..0x29AF walks the 80-byte blocks bank by bank.
// - Common bytes excluded; unimplemented linear places read zero.
// - Top pointer bit set selects flash; low byte read, writes ignored.
// - Flash reads through indirect port add one instruction cycle.
`timescale 1ns/10ps
`default_nettype none
`include "pcs_consts.vh"
module pcs_core
#(
   parameter DEPTH = 16
)
(
   // Clock and reset
   input  wire        sys_clk,
   input  wire        resetn,
   // Avalon-MM slave
   input  wire [5:0]  avs_address,
   input  wire        avs_read,
   input  wire        avs_write,
   input  wire [31:0] avs_writedata,
   output reg  [31:0] avs_readdata,
   output reg         avs_waitrequest,
   // Indirect access result
   output reg  [1:0]  ind_kind,
   output reg  [14:0] ind_addr,
   output reg         ind_suppress,
   output reg         ind_stall,
   // Program counter and fault reset
   output reg  [14:0] pc_out,
   output reg         stack_fault_reset
);
   localparam ST_IDLE = 2'b01;
   localparam ST_DONE = 2'b10;

   reg  [1:0]  state;
   reg  [14:0] pc;
   reg  [6:0]  pc_high_latch;
   reg  [4:0]  stack_pointer;
   reg  [14:0] stack_mem [0:DEPTH-1];
   reg         stack_fault_reset_enable;
   reg         stack_overflow_flag;
   reg         stack_underflow_flag;
   reg         fault_seen;
   reg  [15:0] indirect_pointer0;
   reg  [15:0] indirect_pointer1;
   reg         ptr_sel;
   reg  [1:0]  stall_cnt;
   wire [3:0]  idx;
   wire        req;
   wire [15:0] sel_ptr;
   wire [1:0]  dec_kind;
   wire [14:0] dec_addr;
   wire        dec_self;
   wire [14:0] pc_inc;
   wire [3:0]  tos_idx;
   wire [4:0]  sp_inc;
   wire [4:0]  sp_dec;
   wire [3:0]  cmd;
   wire [10:0] opnd;
   wire [7:0]  wreg;
   wire        do_push;
   wire        do_pop;
   wire        ovf_now;
   wire        unf_now;
   reg  [31:0] next_rdata;

   assign idx     = avs_address[5:2];
   assign req     = avs_read | avs_write;
   assign sel_ptr = ptr_sel ? indirect_pointer1 : indirect_pointer0;
   assign pc_inc  = pc + 15'h0001;
   assign tos_idx = stack_pointer[3:0];
   assign sp_inc  = stack_pointer + 5'h01;
   assign sp_dec  = stack_pointer - 5'h01;
   assign cmd     = avs_writedata[3:0];
   assign wreg    = avs_writedata[15:8];
   assign opnd    = avs_writedata[26:16];

   // =====================================================================
   // Stack event decode
   // A command write on the PC register drives pushes and pops.
   wire cmd_wr = avs_write & ~avs_waitrequest & (idx == `PCS_IDX_PC);
   assign do_push = cmd_wr & ((cmd == `PCS_CMD_CALL) |
                    (cmd == `PCS_CMD_CALL_VIA_WORKING) | (cmd == `PCS_CMD_IRQ));
   assign do_pop  = cmd_wr & ((cmd == `PCS_CMD_RETURN) |
                    (cmd == `PCS_CMD_RETURN_WITH_LITERAL) | (cmd == `PCS_CMD_RETURN_FROM_INTERRUPT));
   // Overflow: pushing when the pointer already sits at the top entry.
   assign ovf_now = do_push & (stack_pointer == `PCS_SP_TOP);
   // Underflow: popping when the stack is empty.
   assign unf_now = do_pop & (stack_pointer == `PCS_SP_EMPTY);

   pcs_ind_decode u_dec
   (
      .ptr      (sel_ptr),
      .kind     (dec_kind),
      .addr     (dec_addr),
      .self_ref (dec_self)
   );

   // =====================================================================
   // Bus handshake
   // Every request waits one cycle, then completes with waitrequest low.
   always @(posedge sys_clk)
   begin
      if (!resetn)
      begin
         state           <= ST_IDLE;
         avs_waitrequest <= 1'b1;
      end
      else
      begin
         case (state)
            ST_IDLE:
            begin
               if (req)
               begin
                  state           <= ST_DONE;
                  avs_waitrequest <= 1'b0;
               end
            end
            ST_DONE:
            begin
               state           <= ST_IDLE;
               avs_waitrequest <= 1'b1;
            end
            default:
            begin
               state           <= ST_IDLE;
               avs_waitrequest <= 1'b1;
            end
         endcase
      end
   end

   // =====================================================================
   // Read mux
   // Unmapped words read as zero.
   always @*
   begin
      next_rdata = 32'h00000000;
      case (idx)
         `PCS_IDX_CTRL:   next_rdata[`PCS_CTRL_STACK_FAULT_RESET_ENABLE] =
                             stack_fault_reset_enable;
         `PCS_IDX_PCL:    next_rdata[7:0] = pc[7:0];
         `PCS_IDX_PC_HIGH_LATCH: next_rdata[6:0] = pc_high_latch;
         `PCS_IDX_PC:     next_rdata[14:0] = pc;
         `PCS_IDX_SP:     next_rdata[4:0] = stack_pointer;
         `PCS_IDX_TOP_OF_STACK_LOW:   next_rdata[7:0] = stack_mem[tos_idx][7:0];
         `PCS_IDX_TOP_OF_STACK_HIGH:   next_rdata[6:0] = stack_mem[tos_idx][14:8];
         `PCS_IDX_FLAGS:
         begin
            next_rdata[`PCS_FLAG_OVF]   = stack_overflow_flag;
            next_rdata[`PCS_FLAG_UNF]   = stack_underflow_flag;
            next_rdata[`PCS_FLAG_FAULT] = fault_seen;
         end
         `PCS_IDX_PTR0:   next_rdata[15:0] = indirect_pointer0;
         `PCS_IDX_PTR1:   next_rdata[15:0] = indirect_pointer1;
         `PCS_IDX_DEC:
            next_rdata = {13'h0000, ptr_sel, dec_self, dec_kind, dec_addr};
         default:         next_rdata = 32'h00000000;
      endcase
   end

   // =====================================================================
   // Register and datapath updates
   // Writes complete on the edge where waitrequest is low.
   always @(posedge sys_clk)
   begin
      if (!resetn)
      begin
         pc                       <= `PCS_PC_RESET;
         pc_high_latch            <= 7'h00;
         stack_pointer            <= `PCS_SP_EMPTY;
         stack_fault_reset_enable <= 1'b0;
         indirect_pointer0        <= 16'h0000;
         indirect_pointer1        <= 16'h0000;
         ptr_sel                  <= 1'b0;
         avs_readdata             <= 32'h00000000;
         stack_fault_reset        <= 1'b0;
         pc_out                   <= `PCS_PC_RESET;
         ind_kind                 <= `PCS_KIND_NONE;
         ind_addr                 <= 15'h0000;
         ind_suppress             <= 1'b0;
         ind_stall                <= 1'b0;
         stall_cnt                <= 2'h0;
      end
      else if ((ovf_now | unf_now) & stack_fault_reset_enable)
      begin
         // Fault reset: PC and pointer back to reset state.
         pc                <= `PCS_PC_RESET;
         pc_out            <= `PCS_PC_RESET;
         stack_pointer     <= `PCS_SP_EMPTY;
         stack_fault_reset <= 1'b1;
      end
      else
      begin
         stack_fault_reset <= 1'b0;
         pc_out            <= pc;
         ind_kind          <= dec_kind;
         ind_addr          <= dec_addr;
         ind_suppress      <= dec_self | (dec_kind == `PCS_KIND_FLASH);
         // Flash reads stretch the instruction one cycle.
         if (stall_cnt != 2'h0)
            stall_cnt <= stall_cnt - 2'h1;
         ind_stall <= (stall_cnt != 2'h0);
         // Read data loads as waitrequest drops, standing at completion.
         if (avs_read & (state == ST_IDLE))
            avs_readdata <= next_rdata;
         if (avs_read & ~avs_waitrequest & (idx == `PCS_IDX_DEC) &
             (dec_kind == `PCS_KIND_FLASH))
            stall_cnt <= `PCS_FLASH_STALL;
         if (avs_write & ~avs_waitrequest)
         begin
            case (idx)
               `PCS_IDX_CTRL:
               begin
                  stack_fault_reset_enable <=
                     avs_writedata[`PCS_CTRL_STACK_FAULT_RESET_ENABLE];
                  ptr_sel <= avs_writedata[0];
               end
               `PCS_IDX_PCL:
                  pc <= {pc_high_latch, avs_writedata[7:0]};
               `PCS_IDX_PC_HIGH_LATCH: pc_high_latch <= avs_writedata[6:0];
               `PCS_IDX_SP:
                  stack_pointer <= avs_writedata[4:0];
               `PCS_IDX_PTR0:  indirect_pointer0 <= avs_writedata[15:0];
               `PCS_IDX_PTR1:  indirect_pointer1 <= avs_writedata[15:0];
               `PCS_IDX_PC:
               begin
                  case (cmd)
                     `PCS_CMD_CALL:
                        pc <= {pc_high_latch[6:3], opnd};
                     `PCS_CMD_CALL_VIA_WORKING:
                        pc <= {pc_high_latch, wreg};
                     `PCS_CMD_BRW:
                        pc <= pc_inc + {7'h00, wreg};
                     `PCS_CMD_BRA:
                        pc <= pc_inc + {{6{opnd[8]}}, opnd[8:0]};
                     `PCS_CMD_IRQ:   pc <= {4'h0, opnd};
                     `PCS_CMD_PCLWR:
                        pc <= {pc_high_latch, wreg};
                     `PCS_CMD_INC:   pc <= pc_inc;
                     `PCS_CMD_RETURN, `PCS_CMD_RETURN_WITH_LITERAL, `PCS_CMD_RETURN_FROM_INTERRUPT:
                        pc <= stack_mem[tos_idx];
                     default:        pc <= pc;
                  endcase
                  // Latch is left alone by push and pop.
                  if (do_push)
                     stack_pointer <= (stack_pointer == `PCS_SP_TOP) ?
                                      5'h00 : sp_inc;
                  else if (do_pop)
                     stack_pointer <= (stack_pointer == 5'h00) ?
                                      `PCS_SP_EMPTY :
                                      sp_dec[4:0] & 5'h0F |
                                      (stack_pointer == `PCS_SP_EMPTY ?
                                       5'h0F : 5'h00);
               end
               default: pc <= pc;
            endcase
         end
      end
   end

   // =====================================================================
   // Stack storage
   // Push stores the return address in the incremented slot.
   wire [3:0] push_slot = (stack_pointer == `PCS_SP_EMPTY ||
                           stack_pointer == `PCS_SP_TOP) ? 4'h0 :
                          sp_inc[3:0];
   always @(posedge sys_clk)
   begin
      if (do_push & ~(ovf_now & stack_fault_reset_enable))
         stack_mem[push_slot] <= (cmd == `PCS_CMD_IRQ) ? pc : pc_inc;
      else if (avs_write & ~avs_waitrequest & (idx == `PCS_IDX_TOP_OF_STACK_LOW))
         stack_mem[tos_idx] <= {stack_mem[tos_idx][14:8],
                                avs_writedata[7:0]};
      else if (avs_write & ~avs_waitrequest & (idx == `PCS_IDX_TOP_OF_STACK_HIGH))
         stack_mem[tos_idx] <= {avs_writedata[6:0],
                                stack_mem[tos_idx][7:0]};
   end

   // =====================================================================
   // Fault flags
   // Sticky; a flag write clears them, a same-cycle event wins.
   always @(posedge sys_clk)
   begin
      if (!resetn)
      begin
         stack_overflow_flag  <= 1'b0;
         stack_underflow_flag <= 1'b0;
         fault_seen           <= 1'b0;
      end
      else
      begin
         if (avs_write & ~avs_waitrequest & (idx == `PCS_IDX_FLAGS))
         begin
            stack_overflow_flag  <= 1'b0;
            stack_underflow_flag <= 1'b0;
            fault_seen           <= 1'b0;
         end
         if (ovf_now)
            stack_overflow_flag <= 1'b1;
         if (unf_now)
            stack_underflow_flag <= 1'b1;
         if ((ovf_now | unf_now) & stack_fault_reset_enable)
            fault_seen <= 1'b1;
      end
   end
endmodule
`default_nettype wire

// File: hdl/pcs_consts.vh
// Purpose: Constants for the program counter, stack and indirect decoder.
// Assumes: Included by bare name from the design files.
// Notes:   Definitions only.
`ifndef PCS_CONSTS_VH
`define PCS_CONSTS_VH
// =====================================================================
// Register map (word index; byte address is index times four)
`define PCS_IDX_CTRL      4'h0
`define PCS_IDX_PCL       4'h1
`define PCS_IDX_PC_HIGH_LATCH    4'h2
`define PCS_IDX_PC        4'h3
`define PCS_IDX_SP        4'h4
`define PCS_IDX_TOP_OF_STACK_LOW      4'h5
`define PCS_IDX_TOP_OF_STACK_HIGH      4'h6
`define PCS_IDX_FLAGS     4'h7
`define PCS_IDX_PTR0      4'h8
`define PCS_IDX_PTR1      4'h9
`define PCS_IDX_DEC       4'hA
// =====================================================================
// Command codes written to the command register
`define PCS_CMD_NONE      4'h0
`define PCS_CMD_CALL      4'h1
`define PCS_CMD_CALL_VIA_WORKING     4'h2
`define PCS_CMD_BRW       4'h3
`define PCS_CMD_BRA       4'h4
`define PCS_CMD_RETURN    4'h5
`define PCS_CMD_RETURN_WITH_LITERAL     4'h6
`define PCS_CMD_RETURN_FROM_INTERRUPT    4'h7
`define PCS_CMD_IRQ       4'h8
`define PCS_CMD_PCLWR     4'h9
`define PCS_CMD_INC       4'hA
// =====================================================================
// Field positions and values
`define PCS_SP_EMPTY      5'h1F
`define PCS_SP_TOP        5'h0F
`define PCS_PC_RESET      15'h0000
`define PCS_CTRL_STACK_FAULT_RESET_ENABLE   4
`define PCS_FLAG_OVF      0
`define PCS_FLAG_UNF      1
`define PCS_FLAG_FAULT    2
// Indirect address regions
`define PCS_TRAD_LAST     16'h0FFF
`define PCS_LIN_FIRST     16'h2000
`define PCS_LIN_LAST      16'h29AF
`define PCS_GPR_BYTES     16'h0050
`define PCS_GPR_START     7'h20
`define PCS_BANK_SHIFT    7
`define PCS_IND_PORT0     7'h00
`define PCS_IND_PORT1     7'h01
`define PCS_KIND_TRAD     2'h0
`define PCS_KIND_LIN      2'h1
`define PCS_KIND_FLASH    2'h2
`define PCS_KIND_NONE     2'h3
`define PCS_FLASH_STALL   2'h1
`endif

// File: hdl/pcs_ind_decode.v
// Purpose: Turns a 16-bit indirect pointer into a data or flash access.
// Assumes: Combinational; the caller registers the results.
// Notes:   Linear region is folded onto the 80-byte block of each bank.
`timescale 1ns/10ps
`default_nettype none
`include "pcs_consts.vh"
module pcs_ind_decode
(
   // Pointer in
   input  wire [15:0] ptr,
   // Decoded access
   output reg  [1:0]  kind,
   output reg  [14:0] addr,
   output reg         self_ref
);
   reg [15:0] off;
   reg [15:0] bank;
   reg [15:0] rem;

   // =====================================================================
   // Region decode
   // Picks the region and forms the physical address.
   always @*
   begin
      off      = ptr - `PCS_LIN_FIRST;
      bank     = off / `PCS_GPR_BYTES;
      rem      = off - bank * `PCS_GPR_BYTES;
      kind     = `PCS_KIND_NONE;
      addr     = 15'h0000;
      self_ref = 1'b0;
      if (ptr[15])
      begin
         kind = `PCS_KIND_FLASH;
         addr = ptr[14:0];
      end
      else if (ptr <= `PCS_TRAD_LAST)
      begin
         kind = `PCS_KIND_TRAD;
         addr = {3'h0, ptr[11:0]};
         // Bank offsets 0 and 1 are the two indirect ports.
         self_ref = (ptr[6:0] == `PCS_IND_PORT0) |
                    (ptr[6:0] == `PCS_IND_PORT1);
      end
      else if (ptr >= `PCS_LIN_FIRST && ptr <= `PCS_LIN_LAST)
      begin
         kind = `PCS_KIND_LIN;
         addr = {bank[7:0], 7'h00} + {8'h00, `PCS_GPR_START}
                + {8'h00, rem[6:0]};
      end
   end
endmodule
`default_nettype wire

// File: tb/pcs_core_asserts.sv
// Purpose: Port-level checks on the program counter and stack block.
// Assumes: One clock, synchronous active-low reset.
// Notes:   Attached to every pcs_core by the bind at the foot.
`timescale 1ns/10ps
`default_nettype none
`include "pcs_consts.vh"
module pcs_core_asserts
#(
   parameter DEPTH = 16
)
(
   // Clock and reset
   input wire logic        sys_clk,
   input wire logic        resetn,
   // Register bus
   input wire logic [5:0]  avs_address,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [31:0] avs_readdata,
   input wire logic        avs_waitrequest,
   // Results
   input wire logic [1:0]  ind_kind,
   input wire logic [14:0] ind_addr,
   input wire logic        ind_suppress,
   input wire logic        ind_stall,
   input wire logic [14:0] pc_out,
   input wire logic        stack_fault_reset
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!resetn);
   // =================================================================
   // Bus handshake steps.
   sequence s_req;
      $rose(avs_read || avs_write);
   endsequence
   sequence s_ack;
      !avs_waitrequest ##1 avs_waitrequest;
   endsequence
   a_bus_answer: assert property (s_req |=> s_ack)
      else $error("bus answer missing or held too long");
   // =================================================================
   // Program counter and stack fault.
   a_pc_reset_zero: assert property ($rose(resetn) |-> pc_out == 15'h0000)
      else $error("program counter not cleared by reset");
   a_fault_pulse: assert property (stack_fault_reset |=> !stack_fault_reset)
      else $error("stack fault reset longer than one cycle");
   a_fault_clears_pc: assert property (stack_fault_reset |-> ##[0:3] pc_out == 15'h0000)
      else $error("stack fault reset left the counter set");
   // =================================================================
   // Indirect decode.
   a_stall_single: assert property (ind_stall |=> !ind_stall)
      else $error("flash stall longer than one cycle");
   a_stall_flash: assert property (ind_stall |-> ind_kind == `PCS_KIND_FLASH)
      else $error("stall without a flash access");
   a_flash_drop: assert property (ind_kind == `PCS_KIND_FLASH |-> ind_suppress)
      else $error("flash write not suppressed");
   a_lin_window: assert property (ind_kind == `PCS_KIND_LIN |-> ind_addr[6:0] >= 7'h20 && ind_addr[6:0] <= 7'h6F && ind_addr[14:7] <= 8'h1E)
      else $error("linear access outside a bank block");
   a_trad_range: assert property (ind_kind == `PCS_KIND_TRAD |-> ind_addr[14:12] == 3'h0)
      else $error("traditional address beyond the data space");
endmodule
bind pcs_core pcs_core_asserts #(.DEPTH(DEPTH)) u_chk
(
   .sys_clk(sys_clk), .resetn(resetn), .avs_address(avs_address),
   .avs_read(avs_read), .avs_write(avs_write),
   .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
   .avs_waitrequest(avs_waitrequest), .ind_kind(ind_kind),
   .ind_addr(ind_addr), .ind_suppress(ind_suppress),
   .ind_stall(ind_stall), .pc_out(pc_out),
   .stack_fault_reset(stack_fault_reset)
);
`default_nettype wire

// File: tb/pcs_dec_model.sv
// Purpose: Instruction decoder model issuing bus accesses to the block.
// Assumes: Caller enters each access just after a rising edge.
// Notes:   A wait that never ends raises hang.
`timescale 1ns/10ps
`default_nettype none
module pcs_dec_model
(
   // Clock and answers
   input  wire logic        sys_clk,
   input  wire logic [31:0] avs_readdata,
   input  wire logic        avs_waitrequest,
   // Requests
   output var  logic [5:0]  avs_address,
   output var  logic        avs_read,
   output var  logic        avs_write,
   output var  logic [31:0] avs_writedata,
   output var  logic        hang
);
   // Bus idles at time zero.
   initial
   begin
      avs_address   = 6'h00;
      avs_read      = 1'b0;
      avs_write     = 1'b0;
      avs_writedata = 32'h00000000;
      hang          = 1'b0;
   end
   // One access: request held until waitrequest is sampled low.
   task automatic access(input logic rd, input logic [3:0] idx,
      input logic [31:0] wd, output logic [31:0] rdata);
      int n;
      n = 0;
      avs_address   <= {idx, 2'b00};
      avs_read      <= rd;
      avs_write     <= ~rd;
      avs_writedata <= wd;
      @(posedge sys_clk);
      while (avs_waitrequest !== 1'b0 && n < 40)
      begin
         @(posedge sys_clk);
         n++;
      end
      if (avs_waitrequest !== 1'b0) hang <= 1'b1;
      // Read data stands at the edge where waitrequest is sampled low.
      rdata = avs_readdata;
      avs_read  <= 1'b0;
      avs_write <= 1'b0;
      // One idle edge keeps back-to-back requests apart.
      @(posedge sys_clk);
   endtask
endmodule
`default_nettype wire

// File: tb/test_pc_stack_indirect_addressing.sv
// Purpose: Self-checking bench for the counter, stack and decoder.
// Assumes: Commands reach the block as register writes.
// Notes:   Expected values come from the register map and the rules.
`timescale 1ns/10ps
`default_nettype none
`include "pcs_consts.vh"
module test_pc_stack_indirect_addressing;
   localparam logic [3:0] IX_LOW = 4'h1, IX_LATCH = 4'h2;
   localparam logic [3:0] IX_TLO = 4'h5, IX_THI = 4'h6;
   localparam logic [3:0] C_CW = 4'h2, C_BW = 4'h3, C_BL = 4'h4;
   localparam logic [3:0] C_RL = 4'h6, C_RI = 4'h7;
   logic sys_clk, resetn, rd_i, wr_i, wait_o, sup_o, stall_o, flt_o;
   logic hang;
   logic [5:0]  addr_i;
   logic [31:0] wd_i, rdata_o, rd;
   logic [1:0]  kind_o, k;
   logic [14:0] iaddr_o, pc_o, a;
   logic [15:0] p;
   logic [15:0] ptrs [10] = '{16'h0123, 16'h0FFF, 16'h0080, 16'h0001,
      16'h2000, 16'h2050, 16'h29AF, 16'h29B0, 16'h1234, 16'hFFFF};
   logic sup;
   int failures = 0, checks_done = 0, stall_cnt = 0, flt_cnt = 0, o, s0;
   // =================================================================
   // Clock and instances.
   initial
   begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end
   pcs_core #(.DEPTH(16)) dut
   (
      .sys_clk(sys_clk), .resetn(resetn), .avs_address(addr_i),
      .avs_read(rd_i), .avs_write(wr_i), .avs_writedata(wd_i),
      .avs_readdata(rdata_o), .avs_waitrequest(wait_o),
      .ind_kind(kind_o), .ind_addr(iaddr_o), .ind_suppress(sup_o),
      .ind_stall(stall_o), .pc_out(pc_o), .stack_fault_reset(flt_o)
   );
   pcs_dec_model u_mdl
   (
      .sys_clk(sys_clk), .avs_readdata(rdata_o),
      .avs_waitrequest(wait_o), .avs_address(addr_i), .avs_read(rd_i),
      .avs_write(wr_i), .avs_writedata(wd_i), .hang(hang)
   );
   // Counts stall pulses; a hung bus ends the run.
   always @(posedge sys_clk) if (stall_o === 1'b1) stall_cnt++;
   always @(posedge sys_clk) if (flt_o === 1'b1) flt_cnt++;
   always @(posedge hang)
   begin
      failures++;
      end_of_test();
   end
   // =================================================================
   // Helpers.
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         failures++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [3:0] idx, input logic [31:0] d);
      u_mdl.access(1'b0, idx, d, rd);
   endtask
   task automatic chk(input logic [3:0] idx, input logic [31:0] exp);
      u_mdl.access(1'b1, idx, 32'h00000000, rd);
      cmp(rd, exp);
   endtask
   task automatic cmd(input logic [3:0] c, input logic [7:0] w,
      input logic [10:0] op);
      wr(`PCS_IDX_PC, {5'h00, op, w, 4'h0, c});
   endtask
   task end_of_test;
      if (failures == 0 && checks_done > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // =================================================================
   // Main sequence.
   initial
   begin
      resetn = 1'b0;
      repeat (8) @(posedge sys_clk);
      resetn <= 1'b1;
      @(posedge sys_clk);
      chk(`PCS_IDX_PC, 32'h0);
      chk(`PCS_IDX_SP, 32'h1F);
      chk(`PCS_IDX_FLAGS, 32'h0);
      chk(4'hB, 32'h0);
      wr(IX_LATCH, 32'h55);
      wr(IX_LOW, 32'h34);
      chk(`PCS_IDX_PC, 32'h5534);
      chk(IX_LOW, 32'h34);
      cmp({17'h0, pc_o}, 32'h5534);
      cmd(`PCS_CMD_CALL, 8'h00, 11'h7AB);
      chk(`PCS_IDX_PC, 32'h57AB);
      chk(`PCS_IDX_SP, 32'h0);
      chk(IX_TLO, 32'h35);
      chk(IX_THI, 32'h55);
      chk(IX_LATCH, 32'h55);
      cmd(C_CW, 8'h12, 11'h000);
      chk(`PCS_IDX_PC, 32'h5512);
      cmd(C_BW, 8'hF0, 11'h000);
      chk(`PCS_IDX_PC, 32'h5603);
      cmd(C_BL, 8'h00, 11'h1F0);
      chk(`PCS_IDX_PC, 32'h55F4);
      cmd(`PCS_CMD_INC, 8'h00, 11'h000);
      chk(`PCS_IDX_PC, 32'h55F5);
      cmd(`PCS_CMD_PCLWR, 8'h9A, 11'h000);
      chk(`PCS_IDX_PC, 32'h559A);
      cmd(`PCS_CMD_RETURN, 8'h00, 11'h000);
      chk(`PCS_IDX_PC, 32'h57AC);
      cmd(C_RL, 8'h00, 11'h000);
      chk(`PCS_IDX_PC, 32'h5535);
      chk(`PCS_IDX_SP, 32'h1F);
      cmd(C_RI, 8'h00, 11'h000);
      chk(`PCS_IDX_FLAGS, 32'h2);
      wr(`PCS_IDX_FLAGS, 32'h7);
      wr(`PCS_IDX_SP, 32'h1F);
      wr(IX_LOW, 32'h00);
      cmd(`PCS_CMD_NONE, 8'h00, 11'h000);
      chk(`PCS_IDX_PC, 32'h5500);
      for (int i = 0; i < 17; i++) cmd(`PCS_CMD_IRQ, 8'h00, 11'h100 + i);
      chk(`PCS_IDX_SP, 32'h0);
      chk(`PCS_IDX_FLAGS, 32'h1);
      chk(IX_TLO, 32'h0F);
      wr(`PCS_IDX_SP, 32'h5);
      chk(IX_TLO, 32'h04);
      chk(IX_THI, 32'h01);
      wr(IX_TLO, 32'h77);
      chk(IX_TLO, 32'h77);
      cmd(`PCS_CMD_RETURN, 8'h00, 11'h000);
      chk(`PCS_IDX_PC, 32'h177);
      chk(`PCS_IDX_SP, 32'h4);
      wr(`PCS_IDX_FLAGS, 32'h7);
      wr(`PCS_IDX_CTRL, 32'h10);
      wr(`PCS_IDX_SP, 32'h0F);
      cmd(`PCS_CMD_CALL, 8'h00, 11'h001);
      chk(`PCS_IDX_PC, 32'h0);
      chk(`PCS_IDX_SP, 32'h1F);
      chk(`PCS_IDX_FLAGS, 32'h5);
      wr(`PCS_IDX_FLAGS, 32'h7);
      wr(IX_LOW, 32'h10);
      cmd(`PCS_CMD_RETURN, 8'h00, 11'h000);
      chk(`PCS_IDX_PC, 32'h0);
      chk(`PCS_IDX_FLAGS, 32'h6);
      cmp(flt_cnt, 32'h2);
      wr(`PCS_IDX_CTRL, 32'h0);
      // Pointer decode against the address regions.
      for (int i = 0; i < 10; i++)
      begin
         p = ptrs[i];
         o = int'(p) - 32'h2000;
         sup = 1'b0;
         k = `PCS_KIND_NONE;
         a = 15'h0000;
         if (p[15])
         begin
            k = `PCS_KIND_FLASH;
            a = p[14:0];
            sup = 1'b1;
         end
         else if (p <= `PCS_TRAD_LAST)
         begin
            k = `PCS_KIND_TRAD;
            a = p[14:0];
            sup = (p[6:0] <= 7'h01);
         end
         else if (p >= `PCS_LIN_FIRST && p <= `PCS_LIN_LAST)
         begin
            k = `PCS_KIND_LIN;
            a = 15'(((o / 80) << 7) | (32 + o % 80));
         end
         wr(`PCS_IDX_PTR0, {16'h0000, p});
         s0 = stall_cnt;
         chk(`PCS_IDX_DEC, {13'h0, 1'b0, sup & (k == `PCS_KIND_TRAD), k, a});
         repeat (2) @(posedge sys_clk);
         cmp({30'h0, kind_o}, {30'h0, k});
         if (k != `PCS_KIND_NONE) cmp({17'h0, iaddr_o}, {17'h0, a});
         if (k != `PCS_KIND_NONE) cmp({31'h0, sup_o}, {31'h0, sup});
         cmp(stall_cnt - s0, {31'h0, k == `PCS_KIND_FLASH});
      end
      wr(`PCS_IDX_CTRL, 32'h1);
      wr(`PCS_IDX_PTR1, 32'h8042);
      chk(`PCS_IDX_DEC, 32'h00050042);
      cmp({17'h0, iaddr_o}, 32'h0042);
      wr(IX_LOW, 32'h21);
      wr(`PCS_IDX_SP, 32'h3);
      resetn <= 1'b0;
      repeat (3) @(posedge sys_clk);
      resetn <= 1'b1;
      @(posedge sys_clk);
      chk(`PCS_IDX_PC, 32'h0);
      chk(`PCS_IDX_SP, 32'h1F);
      end_of_test();
   end
endmodule
`default_nettype wire
